// [rtl/psf_bank_ram.sv]
// Four banks of eight general registers, one write and one read port.
// Assumes the caller already folded the bank select into the address.
`timescale 1ns/1ps
module psf_bank_ram
    import psf_pkg::*;
#(
    parameter int ADDR_W = 5
)
(
    input  wire logic              sys_clk,
    input  wire logic              wrEn,
    input  wire logic [ADDR_W-1:0] wrAddr,
    input  wire logic [7:0]        wrData,
    input  wire logic [ADDR_W-1:0] rdAddr,
    output logic      [7:0]        rdData
);

    logic [7:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge sys_clk)
    begin
        if (wrEn)
        begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end

endmodule

// [rtl/psf_pkg.sv]
// Package for the program status word block: SFR addresses, bit positions,
// reset values and the ALU result carrier.
// Assumes the core presents SFR accesses as byte/bit strobes on sys_clk.
package psf_pkg;

    // ==========================================================
    // SFR addresses
    localparam logic [7:0] PSF_ADDR_STATUS = 8'hD0;
    localparam logic [7:0] PSF_ADDR_ACC    = 8'hE0;

    // ==========================================================
    // Status word bit positions
    localparam int PSF_BIT_CARRY  = 7;
    localparam int PSF_BIT_AUX    = 6;
    localparam int PSF_BIT_USERA  = 5;
    localparam int PSF_BIT_BANKHI = 4;
    localparam int PSF_BIT_BANKLO = 3;
    localparam int PSF_BIT_OVF    = 2;
    localparam int PSF_BIT_USERB  = 1;
    localparam int PSF_BIT_PARITY = 0;

    // ==========================================================
    // Reset values and bank geometry
    localparam logic [7:0] PSF_STATUS_RESET = 8'h00;
    localparam logic [7:0] PSF_ACC_RESET    = 8'h00;
    localparam int         PSF_BANK_REGS    = 8;
    localparam int         PSF_BANKS        = 4;

    // ==========================================================
    // Operation kinds reported by the ALU; all but PSF_OP_OTHR are arithmetic
    typedef enum logic [2:0]
    {
        PSF_OP_ADD  = 3'h0,
        PSF_OP_ADD_WITH_CARRY_OP = 3'h1,
        PSF_OP_SUBTRACT_BORROW_OP = 3'h2,
        PSF_OP_MUL  = 3'h3,
        PSF_OP_DIV  = 3'h4,
        PSF_OP_OTHR = 3'h5
    } psf_op_e;

    // One-cycle result report from the ALU
    typedef struct packed
    {
        logic       valid;
        psf_op_e    op;
        logic       carry;
        logic       auxCarry;
        logic       overflow;
        logic       accWrite;
        logic [7:0] accData;
    } psf_alu_s;

    // Software SFR access
    typedef struct packed
    {
        logic       wrByte;
        logic       wrBit;
        logic [2:0] bitSel;
        logic       bitVal;
        logic [7:0] addr;
        logic [7:0] data;
    } psf_sfr_s;

endpackage

// [rtl/psf_status_word.sv]
// Program status word, accumulator and banked general registers.
// Assumes the ALU reports at most one result per cycle; a software
// access may coincide with it.
//
// Behaviour
// - Carry bit 7 follows carry or borrow of last arithmetic op.
// - Aux carry bit 6 follows nibble carry or borrow of last arithmetic op.
// - Bits 5 and 1 are software flags; hardware never changes them.
// - Bank select bits 4-3 choose bank base 0x00, 0x08, 0x10, 0x18.
// - Overflow bit 2 set on signed overflow, MUL over 255, DIV by zero.
// - Those five ops clear overflow in every other case.
// - Parity bit 0 is one when accumulator has odd count of ones.
// - Parity is read-only; bits 7 to 1 are writable by software.
// - Status word sits at SFR 0xD0 with bit access.
// - Accumulator sits at SFR 0xE0.
// - Eight byte registers per bank; only the selected bank is used.
`timescale 1ns/1ps
module psf_status_word
    import psf_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire psf_alu_s   aluRes,
    input  wire psf_sfr_s   sfrReq,
    input  wire logic [7:0] sfrRdAddr,
    input  wire logic       gprWrEn,
    input  wire logic [2:0] gprIdx,
    input  wire logic [7:0] gprWrData,
    output logic      [7:0] sfrRdData,
    output logic      [7:0] statusWord,
    output logic      [7:0] accumulatorOut,
    output logic      [1:0] activeBank,
    output logic      [7:0] gprRdData
);

    // ==========================================================
    // Decode
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] accumulator_reg;
    logic [7:0] accumulator_next;
    logic [7:0] sfrRd_reg;
    logic [7:0] sfrRd_next;

    wire        hitStatus    = (sfrReq.addr == PSF_ADDR_STATUS);
    wire        hitAcc       = (sfrReq.addr == PSF_ADDR_ACC);
    wire        wrStatusByte = sfrReq.wrByte && hitStatus;
    wire        wrStatusBit  = sfrReq.wrBit && hitStatus;
    wire        wrAccByte    = sfrReq.wrByte && hitAcc;
    wire        wrAccBit     = sfrReq.wrBit && hitAcc;
    wire        arith        = aluRes.valid && (aluRes.op != PSF_OP_OTHR);
    wire        ovfOp        = arith;
    wire [7:0]  bitMask      = 8'h01 << sfrReq.bitSel;

    // Software view of status: bit-set/clear or whole byte
    wire [7:0]  swStatus     = wrStatusByte ? sfrReq.data
                             : (sfrReq.bitVal ? (status_reg | bitMask)
                                              : (status_reg & ~bitMask));
    wire [7:0]  swAcc        = wrAccByte ? sfrReq.data
                             : (sfrReq.bitVal ? (accumulator_reg | bitMask)
                                              : (accumulator_reg & ~bitMask));

    // ==========================================================
    // Accumulator
    always_comb
    begin
        accumulator_next = accumulator_reg;
        if (wrAccByte || wrAccBit)
        begin
            accumulator_next = swAcc;
        end
        else if (aluRes.valid && aluRes.accWrite)
        begin
            accumulator_next = aluRes.accData;
        end
    end

    // ==========================================================
    // Status word; hardware flag update wins over a software write
    // in the same cycle, so no arithmetic result is lost.
    always_comb
    begin
        status_next = status_reg;
        if (wrStatusByte || wrStatusBit)
        begin
            status_next[7:1] = swStatus[7:1];
        end
        if (arith)
        begin
            status_next[PSF_BIT_CARRY] = aluRes.carry;
            status_next[PSF_BIT_AUX]   = aluRes.auxCarry;
        end
        if (ovfOp)
        begin
            status_next[PSF_BIT_OVF] = aluRes.overflow;
        end
        // Parity from the next accumulator value, never from software
        status_next[PSF_BIT_PARITY] = ^accumulator_next;
    end

    // ==========================================================
    // SFR read
    always_comb
    begin
        sfrRd_next = 8'h00;
        if (sfrRdAddr == PSF_ADDR_STATUS)
        begin
            sfrRd_next = status_reg;
        end
        else if (sfrRdAddr == PSF_ADDR_ACC)
        begin
            sfrRd_next = accumulator_reg;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_reg      <= PSF_STATUS_RESET;
            accumulator_reg <= PSF_ACC_RESET;
            sfrRd_reg       <= 8'h00;
        end
        else
        begin
            status_reg      <= status_next;
            accumulator_reg <= accumulator_next;
            sfrRd_reg       <= sfrRd_next;
        end
    end

    // ==========================================================
    // Register banks: the bank select forms the top address bits
    wire [1:0] bankSel = status_reg[PSF_BIT_BANKHI:PSF_BIT_BANKLO];
    wire [4:0] gprAddr = {bankSel, gprIdx};

    psf_bank_ram #(
        .ADDR_W ($clog2(PSF_BANKS * PSF_BANK_REGS))
    ) u_bank_ram (
        .sys_clk (sys_clk),
        .wrEn    (gprWrEn),
        .wrAddr  (gprAddr),
        .wrData  (gprWrData),
        .rdAddr  (gprAddr),
        .rdData  (gprRdData)
    );

    assign sfrRdData      = sfrRd_reg;
    assign statusWord     = status_reg;
    assign accumulatorOut = accumulator_reg;
    assign activeBank     = status_reg[PSF_BIT_BANKHI:PSF_BIT_BANKLO];

    // ==========================================================
    // Checks
    property p_carry;
        @(posedge sys_clk) disable iff (!resetn)
        arith |=> statusWord[PSF_BIT_CARRY] == $past(aluRes.carry);
    endproperty
    a_carry: assert property (p_carry) else $error("carry flag mismatch");

    property p_aux;
        @(posedge sys_clk) disable iff (!resetn)
        arith |=> statusWord[PSF_BIT_AUX] == $past(aluRes.auxCarry);
    endproperty
    a_aux: assert property (p_aux) else $error("aux carry mismatch");

    property p_user;
        @(posedge sys_clk) disable iff (!resetn)
        !(sfrReq.wrByte || sfrReq.wrBit) || !hitStatus
            |=> $stable({statusWord[PSF_BIT_USERA], statusWord[PSF_BIT_USERB]});
    endproperty
    a_user: assert property (p_user) else $error("user flag changed by hardware");

    property p_bank;
        @(posedge sys_clk) disable iff (!resetn)
        wrStatusByte |=> activeBank == $past(sfrReq.data[PSF_BIT_BANKHI:PSF_BIT_BANKLO]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank select not applied");

    property p_ovf;
        @(posedge sys_clk) disable iff (!resetn)
        ovfOp |=> statusWord[PSF_BIT_OVF] == $past(aluRes.overflow);
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag mismatch");

    property p_ovf_hold;
        @(posedge sys_clk) disable iff (!resetn)
        !ovfOp && !(sfrReq.wrByte && hitStatus) && !(sfrReq.wrBit && hitStatus)
            |=> $stable(statusWord[PSF_BIT_OVF]);
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("overflow changed unexpectedly");

    property p_parity;
        @(posedge sys_clk) disable iff (!resetn)
        1'b1 |-> statusWord[PSF_BIT_PARITY] == ($countones(accumulatorOut) % 2 == 1);
    endproperty
    a_parity: assert property (p_parity) else $error("parity does not match accumulator");

    property p_swwrite;
        @(posedge sys_clk) disable iff (!resetn)
        wrStatusByte && !arith |=> statusWord[7:1] == $past(sfrReq.data[7:1]);
    endproperty
    a_swwrite: assert property (p_swwrite) else $error("status byte write lost");

    property p_accwrite;
        @(posedge sys_clk) disable iff (!resetn)
        wrAccByte |=> accumulatorOut == $past(sfrReq.data);
    endproperty
    a_accwrite: assert property (p_accwrite) else $error("accumulator write lost");

    property p_bank_hold;
        @(posedge sys_clk) disable iff (!resetn)
        !wrStatusByte && !wrStatusBit |=> $stable(activeBank);
    endproperty
    a_bank_hold: assert property (p_bank_hold) else $error("bank select changed without a write");

    // Ops outside the arithmetic set leave the flags alone
    property p_carry_other;
        @(posedge sys_clk) disable iff (!resetn)
        aluRes.valid && (aluRes.op == PSF_OP_OTHR) && !wrStatusByte && !wrStatusBit
            |=> $stable(statusWord[PSF_BIT_CARRY]);
    endproperty
    a_carry_other: assert property (p_carry_other) else $error("carry changed by other op");

    property p_aux_other;
        @(posedge sys_clk) disable iff (!resetn)
        aluRes.valid && (aluRes.op == PSF_OP_OTHR) && !wrStatusByte && !wrStatusBit
            |=> $stable(statusWord[PSF_BIT_AUX]);
    endproperty
    a_aux_other: assert property (p_aux_other) else $error("aux carry changed by other op");

    // Collision: software still owns the bits hardware never touches
    property p_sw_share;
        @(posedge sys_clk) disable iff (!resetn)
        arith && wrStatusByte
            |=> {statusWord[5:3], statusWord[1]} == $past({sfrReq.data[5:3], sfrReq.data[1]});
    endproperty
    a_sw_share: assert property (p_sw_share) else $error("software bits lost on collision");

    // ==========================================================
    // Checks: software read path and bit access
    property p_status_rd;
        @(posedge sys_clk) disable iff (!resetn)
        sfrRdAddr == PSF_ADDR_STATUS |=> sfrRdData == $past(statusWord);
    endproperty
    a_status_rd: assert property (p_status_rd) else $error("status word read mismatch");

    property p_parity_rd;
        @(posedge sys_clk) disable iff (!resetn)
        sfrRdAddr == PSF_ADDR_STATUS
            |=> sfrRdData[PSF_BIT_PARITY] == ($countones($past(accumulatorOut)) % 2 == 1);
    endproperty
    a_parity_rd: assert property (p_parity_rd) else $error("parity read back wrong");

    property p_acc_rd;
        @(posedge sys_clk) disable iff (!resetn)
        sfrRdAddr == PSF_ADDR_ACC |=> sfrRdData == $past(accumulatorOut);
    endproperty
    a_acc_rd: assert property (p_acc_rd) else $error("accumulator read mismatch");

    // Unmapped addresses read as zero, never as stale data
    property p_other_rd;
        @(posedge sys_clk) disable iff (!resetn)
        (sfrRdAddr != PSF_ADDR_STATUS) && (sfrRdAddr != PSF_ADDR_ACC) |=> sfrRdData == 8'h00;
    endproperty
    a_other_rd: assert property (p_other_rd) else $error("unmapped address read nonzero");

    // Bit 0 excluded: parity ignores writes
    property p_bit_wr;
        @(posedge sys_clk) disable iff (!resetn)
        wrStatusBit && !arith && (sfrReq.bitSel != 3'h0)
            |=> statusWord[$past(sfrReq.bitSel)] == $past(sfrReq.bitVal);
    endproperty
    a_bit_wr: assert property (p_bit_wr) else $error("status bit write lost");

    property p_acc_bit;
        @(posedge sys_clk) disable iff (!resetn)
        wrAccBit |=> accumulatorOut[$past(sfrReq.bitSel)] == $past(sfrReq.bitVal);
    endproperty
    a_acc_bit: assert property (p_acc_bit) else $error("accumulator bit write lost");

    // Parity must follow an arithmetic result in the very next cycle
    property p_acc_alu;
        @(posedge sys_clk) disable iff (!resetn)
        aluRes.valid && aluRes.accWrite && !wrAccByte && !wrAccBit
            |=> accumulatorOut == $past(aluRes.accData)
                && statusWord[PSF_BIT_PARITY] == ^$past(aluRes.accData);
    endproperty
    a_acc_alu: assert property (p_acc_alu) else $error("accumulator or parity lagging");

    property p_acc_hold;
        @(posedge sys_clk) disable iff (!resetn)
        !wrAccByte && !wrAccBit && !(aluRes.valid && aluRes.accWrite) |=> $stable(accumulatorOut);
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("accumulator changed without a write");

    c_carry_set: cover property (@(posedge sys_clk) arith && aluRes.carry);
    c_bank3:     cover property (@(posedge sys_clk) activeBank == 2'b11);
    c_ovf_set:   cover property (@(posedge sys_clk) ovfOp && aluRes.overflow);
    c_parity:    cover property (@(posedge sys_clk) statusWord[PSF_BIT_PARITY]);
    c_collide:   cover property (@(posedge sys_clk) arith && wrStatusByte);

endmodule

// [sim/psf_alu_model.sv]
// Arithmetic unit model that feeds result reports to the status word.
// Assumes the bench drives go and operands off the rising edge.
`timescale 1ns/1ps
module psf_alu_model
    import psf_pkg::*;
(
    input  wire logic       go,
    input  wire psf_op_e    op,
    input  wire logic [7:0] opA,
    input  wire logic [7:0] opB,
    input  wire logic       carryIn,
    output psf_alu_s        res
);
    logic [8:0]  sum;
    logic [8:0]  diff;
    logic [4:0]  nibSum;
    logic [4:0]  nibDif;
    logic [15:0] prod;
    logic        cinEff;
    assign cinEff = (op == PSF_OP_ADD) ? 1'b0 : carryIn;
    assign sum    = {1'b0, opA} + {1'b0, opB} + 9'(cinEff);
    assign diff   = {1'b0, opA} - {1'b0, opB} - 9'(carryIn);
    assign nibSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + 5'(cinEff);
    assign nibDif = {1'b0, opA[3:0]} - {1'b0, opB[3:0]} - 5'(carryIn);
    assign prod   = 16'(opA) * 16'(opB);
    always_comb
    begin
        res          = '0;
        res.valid    = go;
        res.op       = op;
        res.accWrite = go;
        case (op)
            PSF_OP_ADD, PSF_OP_ADD_WITH_CARRY_OP:
            begin
                res.carry    = sum[8];
                res.auxCarry = nibSum[4];
                res.overflow = (opA[7] == opB[7]) && (sum[7] != opA[7]);
                res.accData  = sum[7:0];
            end
            PSF_OP_SUBTRACT_BORROW_OP:
            begin
                res.carry    = diff[8];
                res.auxCarry = nibDif[4];
                res.overflow = (opA[7] != opB[7]) && (diff[7] != opA[7]);
                res.accData  = diff[7:0];
            end
            PSF_OP_MUL:
            begin
                res.overflow = |prod[15:8];
                res.accData  = prod[7:0];
            end
            PSF_OP_DIV:
            begin
                // Quotient of zero chosen for a zero divisor
                res.overflow = (opB == 8'h00);
                res.accData  = (opB == 8'h00) ? 8'h00 : opA / opB;
            end
            default: res.accWrite = 1'b0;
        endcase
    end
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the status word block.
// Assumes inputs change at the falling edge only.
`timescale 1ns/1ps
module tb_top
    import psf_pkg::*;
;
    logic       sys_clk, resetn, go, carryIn, gprWrEn;
    psf_op_e    op;
    logic [7:0] opA, opB, sfrRdAddr, gprWrData, sfrRdData, statusWord, accumulatorOut, gprRdData;
    logic [2:0] gprIdx;
    logic [1:0] activeBank;
    psf_alu_s   aluRes;
    psf_sfr_s   sfrReq;
    int         numErrors, checkCount, cycles;
    typedef struct packed {psf_op_e op; logic [7:0] a; logic [7:0] b; logic cin; logic [2:0] f; logic [7:0] acc;} psf_row_s;
    // Flags column is carry, aux carry, overflow
    psf_row_s rows [9] = '{'{PSF_OP_ADD, 8'h7F, 8'h01, 1'b0, 3'b011, 8'h80},
        '{PSF_OP_ADD, 8'hFF, 8'h01, 1'b0, 3'b110, 8'h00}, '{PSF_OP_ADD_WITH_CARRY_OP, 8'h10, 8'h20, 1'b1, 3'b000, 8'h31},
        '{PSF_OP_SUBTRACT_BORROW_OP, 8'h00, 8'h01, 1'b0, 3'b110, 8'hFF}, '{PSF_OP_SUBTRACT_BORROW_OP, 8'h80, 8'h01, 1'b0, 3'b011, 8'h7F},
        '{PSF_OP_MUL, 8'h10, 8'h10, 1'b0, 3'b001, 8'h00}, '{PSF_OP_MUL, 8'h03, 8'h05, 1'b0, 3'b000, 8'h0F},
        '{PSF_OP_DIV, 8'h07, 8'h00, 1'b0, 3'b001, 8'h00}, '{PSF_OP_DIV, 8'h09, 8'h02, 1'b0, 3'b000, 8'h04}};

    psf_alu_model i_alu (.go(go), .op(op), .opA(opA), .opB(opB), .carryIn(carryIn), .res(aluRes));
    psf_status_word i_dut (.sys_clk(sys_clk), .resetn(resetn), .aluRes(aluRes), .sfrReq(sfrReq),
        .sfrRdAddr(sfrRdAddr), .gprWrEn(gprWrEn), .gprIdx(gprIdx), .gprWrData(gprWrData),
        .sfrRdData(sfrRdData), .statusWord(statusWord), .accumulatorOut(accumulatorOut),
        .activeBank(activeBank), .gprRdData(gprRdData));

    // ==========================================================
    // Helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic sfrWr(input logic [7:0] a, input logic [7:0] d, input logic isBit);
        @(negedge sys_clk);
        sfrReq = '{~isBit, isBit, a[2:0], d[0], isBit ? PSF_ADDR_STATUS : a, d};
        @(negedge sys_clk);
        sfrReq = '0;
    endtask
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", checkCount, numErrors);
        if (numErrors == 0 && checkCount > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the expected run of some 80 cycles
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            numErrors++;
            wrapUp();
        end
    end

    // ==========================================================
    // Sequence
    initial
    begin
        {resetn, go, carryIn, gprWrEn, opA, opB, sfrRdAddr, gprWrData, gprIdx} = '0;
        op = PSF_OP_ADD;
        sfrReq = '0;
        repeat (3) @(negedge sys_clk);
        check(statusWord | accumulatorOut | sfrRdData | 8'(activeBank), 8'h00);
        resetn = 1'b1;
        foreach (rows[i])
        begin
            @(negedge sys_clk);
            go      = 1'b1;
            op      = rows[i].op;
            opA     = rows[i].a;
            opB     = rows[i].b;
            carryIn = rows[i].cin;
            @(negedge sys_clk);
            go = 1'b0;
            check(statusWord, {rows[i].f[2:1], 3'b000, rows[i].f[0], 1'b0, ^rows[i].acc});
            check(accumulatorOut, rows[i].acc);
        end
        $display("test alu rows done");
        sfrWr(PSF_ADDR_STATUS, 8'hFF, 1'b0);
        check(statusWord, 8'hFF);
        check(8'(activeBank), 8'h03);
        @(negedge sys_clk);
        go      = 1'b1;
        op      = PSF_OP_ADD;
        opA     = 8'h01;
        opB     = 8'h02;
        carryIn = 1'b0;
        @(negedge sys_clk);
        go = 1'b0;
        check(statusWord, 8'h3A);
        sfrWr(8'h00, 8'h01, 1'b1);
        check(statusWord, 8'h3A);
        sfrWr(8'h04, 8'h00, 1'b1);
        check(statusWord, 8'h2A);
        sfrWr(PSF_ADDR_ACC, 8'h07, 1'b0);
        check(accumulatorOut, 8'h07);
        check(statusWord, 8'h2B);
        foreach (rows[i])
        begin
            if (i < 3)
            begin
                @(negedge sys_clk);
                sfrRdAddr = (i == 0) ? PSF_ADDR_STATUS : (i == 1) ? PSF_ADDR_ACC : 8'hD1;
                @(negedge sys_clk);
                check(sfrRdData, (i == 0) ? 8'h2B : (i == 1) ? 8'h07 : 8'h00);
            end
        end
        $display("test software access done");
        for (int b = 0; b < 4; b++)
        begin
            sfrWr(PSF_ADDR_STATUS, 8'(b << 3), 1'b0);
            @(negedge sys_clk);
            {gprWrEn, gprIdx, gprWrData} = {1'b1, 3'h2, 8'(8'hA0 + b)};
            @(negedge sys_clk);
            gprWrEn = 1'b0;
        end
        for (int b = 3; b >= 0; b--)
        begin
            sfrWr(PSF_ADDR_STATUS, 8'(b << 3), 1'b0);
            repeat (2) @(negedge sys_clk);
            check(gprRdData, 8'(8'hA0 + b));
        end
        $display("test banks done");
        // Software byte write and ALU report in one cycle
        @(negedge sys_clk);
        sfrReq = '{1'b1, 1'b0, 3'h0, 1'b0, PSF_ADDR_STATUS, 8'h22};
        go     = 1'b1;
        op     = PSF_OP_ADD;
        opA    = 8'hFF;
        opB    = 8'h01;
        @(negedge sys_clk);
        sfrReq = '0;
        go     = 1'b0;
        check(statusWord, 8'hE2);
        @(negedge sys_clk);
        go = 1'b1;
        op = PSF_OP_OTHR;
        @(negedge sys_clk);
        go = 1'b0;
        check(statusWord, 8'hE2);
        check(accumulatorOut, 8'h00);
        @(negedge sys_clk);
        sfrReq = '{1'b0, 1'b1, 3'h7, 1'b1, PSF_ADDR_ACC, 8'h00};
        @(negedge sys_clk);
        sfrReq = '0;
        check(accumulatorOut, 8'h80);
        check(statusWord, 8'hE3);
        $display("test awkward cases done");
        @(negedge sys_clk);
        resetn = 1'b0;
        @(negedge sys_clk);
        check(statusWord | accumulatorOut | sfrRdData | 8'(activeBank), 8'h00);
        resetn = 1'b1;
        @(negedge sys_clk);
        go      = 1'b1;
        op      = rows[0].op;
        opA     = rows[0].a;
        opB     = rows[0].b;
        carryIn = rows[0].cin;
        @(negedge sys_clk);
        go = 1'b0;
        check(statusWord, 8'h45);
        $display("test reset done");
        wrapUp();
    end
endmodule
